//--- logic/apss_pkg.sv
// Function
// - Single pass runs each step once, halts, waits for a new run.
// - Cycling mode runs all steps, then wraps to step one forever.
// - While cycling only stop, external fault, emergency stop and leaving operation select 4 act.
// - Stop-intervention pass stops and restarts at each step change.
// - Step one uses main setpoint, others seven step setpoints, 0.01 Hz.
// - Each step lasts its own timer, 0.0 to 6500.0 s in 0.1 s.
// - Direction setting is eight bits, one bit per step.
// - Direction and ramp settings act only when operation select is 4.
// - Ramp code 00..11 picks accel/decel pair one to four.
// - Ramp word has two bits per step, step one lowest.
// - Cycle mode 0 pass, 1 cycling, 2 pass-intervene, 3 cycle-intervene.
// - In program mode external direction input is ignored.
// - Resume memory 1 keeps step and progress across stop or fault.
`default_nettype none
package apss_pkg;
  localparam int unsigned NSTEP       = 8;
  localparam logic [2:0]  LAST_STEP   = 3'h7;
  localparam logic [2:0]  OP_INTERNAL = 3'h4;
  localparam logic [2:0]  OP_MAX      = 3'h5;
  localparam logic [15:0] FREQ_MAX    = 16'h9c40;
  localparam logic [15:0] TIMER_MAX   = 16'hfde8;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TENTH_S_NS    = 100000000;
  localparam int unsigned TICK_CYCLES   = TENTH_S_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    APSS_ONE_PASS,
    APSS_CYCLE,
    APSS_PASS_STOP,
    APSS_CYCLE_STOP
  } apss_mode_e;

  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_DIR    = 5'h01;
  localparam logic [4:0] REG_RAMP   = 5'h02;
  localparam logic [4:0] REG_STATUS = 5'h03;
  localparam logic [4:0] REG_REMAIN = 5'h04;
  localparam logic [4:0] REG_FREQ0  = 5'h08;
  localparam logic [4:0] REG_TIMER0 = 5'h10;
  localparam logic [4:0] REG_LAST   = 5'h17;

  localparam int unsigned CTRL_OP_LSB   = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_RES_BIT  = 8;
  localparam int unsigned STAT_STEP_LSB = 4;
  localparam int unsigned STAT_HELD_BIT = 8;

  localparam logic [NSTEP-1:0][15:0] FREQ_RST = {
    16'h0032, 16'h0fa0, 16'h0dac, 16'h0bb8,
    16'h09c4, 16'h07d0, 16'h05dc, 16'h0000};
  localparam logic [NSTEP-1:0][15:0] TIMER_RST = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0064, 16'h0064};
endpackage : apss_pkg
`default_nettype wire

//--- logic/apss_sequencer.sv
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module apss_sequencer #(
  parameter int unsigned TICK_CYCLES = apss_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave, byte address
  input  wire logic [6:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Operator commands
  input  wire logic        run_cmd_in,
  input  wire logic        stop_cmd_in,
  input  wire logic        ext_fault_in,
  input  wire logic        estop_in,
  input  wire logic        ext_reverse_in,
  // Ramp generator
  input  wire logic        drive_stopped_in,
  output logic             run_out,
  output logic      [15:0] freq_out,
  output logic             reverse_out,
  output logic      [1:0]  ramp_pair_out,
  output logic      [2:0]  step_out
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {APSS_IDLE, APSS_RUN, APSS_GAP} apss_st_e;

  typedef struct packed {
    apss_st_e                  st;
    logic [2:0]                step;
    logic [15:0]               remain;
    logic [TW-1:0]             tick;
    logic                      held;
    logic                      done;
    logic                      man_run;
    logic [2:0]                op;
    apss_pkg::apss_mode_e      mode;
    logic                      resume;
    logic [7:0]                dir;
    logic [15:0]               ramp;
    logic [apss_pkg::NSTEP-1:0][15:0] freq;
    logic [apss_pkg::NSTEP-1:0][15:0] timer;
    logic                      wait_r;
    logic [31:0]               rdata;
    logic                      run;
    logic [15:0]               fout;
    logic                      rev;
    logic [1:0]                rsel;
  } apss_state_s;

  apss_state_s s_r;
  apss_state_s s_nxt;

  function automatic logic [1:0] ramp_of(input logic [15:0] w, input logic [2:0] k);
    ramp_of = w[{k, 1'b0} +: 2];
  endfunction : ramp_of

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] m);
    clamp = (v > m) ? m : v;
  endfunction : clamp

  logic [4:0] idx;
  logic       req;
  logic       accept;
  logic       halt;
  logic       prog;
  logic       adv;
  logic       last;

  assign idx    = avs_address_in[6:2];
  assign req    = avs_read_in | avs_write_in;
  assign accept = req & ~s_r.wait_r;
  assign halt   = stop_cmd_in | ext_fault_in | estop_in;
  assign prog   = (s_r.op == apss_pkg::OP_INTERNAL);
  assign last   = (s_r.step == apss_pkg::LAST_STEP);
  // A zero timer advances at once, so in modes 0 and 1 (no stop-intervention) unused steps cost one clock only.
  assign adv    = (s_r.st == APSS_RUN) && (s_r.remain == 16'h0000);

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;

    // Bus slave: one wait cycle, then accept on the edge with waitrequest low.
    if (accept) begin
      s_nxt.wait_r = 1'b1;
    end else if (req) begin
      s_nxt.wait_r = 1'b0;
      s_nxt.rdata  = 32'h0000_0000;
      if (idx == apss_pkg::REG_CTRL) begin
        s_nxt.rdata[apss_pkg::CTRL_OP_LSB +: 3]   = s_r.op;
        s_nxt.rdata[apss_pkg::CTRL_MODE_LSB +: 2] = s_r.mode;
        s_nxt.rdata[apss_pkg::CTRL_RES_BIT]       = s_r.resume;
      end else if (idx == apss_pkg::REG_DIR) begin
        s_nxt.rdata[7:0] = s_r.dir;
      end else if (idx == apss_pkg::REG_RAMP) begin
        s_nxt.rdata[15:0] = s_r.ramp;
      end else if (idx == apss_pkg::REG_STATUS) begin
        s_nxt.rdata[1:0] = s_r.st;
        s_nxt.rdata[apss_pkg::STAT_STEP_LSB +: 3] = s_r.step;
        s_nxt.rdata[apss_pkg::STAT_HELD_BIT]      = s_r.held;
      end else if (idx == apss_pkg::REG_REMAIN) begin
        s_nxt.rdata[15:0] = s_r.remain;
      end else if (idx >= apss_pkg::REG_FREQ0 && idx < apss_pkg::REG_TIMER0) begin
        s_nxt.rdata[15:0] = s_r.freq[idx[2:0]];
      end else if (idx >= apss_pkg::REG_TIMER0 && idx <= apss_pkg::REG_LAST) begin
        s_nxt.rdata[15:0] = s_r.timer[idx[2:0]];
      end
    end

    if (accept && avs_write_in) begin
      if (idx == apss_pkg::REG_CTRL) begin
        if (avs_writedata_in[apss_pkg::CTRL_OP_LSB +: 3] <= apss_pkg::OP_MAX) begin
          s_nxt.op = avs_writedata_in[apss_pkg::CTRL_OP_LSB +: 3];
        end
        s_nxt.mode   = apss_pkg::apss_mode_e'(avs_writedata_in[apss_pkg::CTRL_MODE_LSB +: 2]);
        s_nxt.resume = avs_writedata_in[apss_pkg::CTRL_RES_BIT];
      end else if (idx == apss_pkg::REG_DIR) begin
        s_nxt.dir = avs_writedata_in[7:0];
      end else if (idx == apss_pkg::REG_RAMP) begin
        s_nxt.ramp = avs_writedata_in[15:0];
      end else if (idx >= apss_pkg::REG_FREQ0 && idx < apss_pkg::REG_TIMER0) begin
        s_nxt.freq[idx[2:0]] = clamp(avs_writedata_in[15:0], apss_pkg::FREQ_MAX);
      end else if (idx >= apss_pkg::REG_TIMER0 && idx <= apss_pkg::REG_LAST) begin
        s_nxt.timer[idx[2:0]] = clamp(avs_writedata_in[15:0], apss_pkg::TIMER_MAX);
      end
    end

    // Sequencer.
    case (s_r.st)
      APSS_IDLE: begin
        if (!prog) begin
          if (halt) begin
            s_nxt.man_run = 1'b0;
          end else if (run_cmd_in) begin
            s_nxt.man_run = 1'b1;
          end
        end else begin
          s_nxt.man_run = 1'b0;
          if (run_cmd_in && !halt) begin
            s_nxt.st   = APSS_RUN;
            s_nxt.tick = '0;
            if (!(s_r.held && s_r.resume)) begin
              s_nxt.step   = 3'h0;
              s_nxt.remain = s_r.timer[0];
            end
            s_nxt.held = 1'b0;
          end
        end
      end
      APSS_RUN, APSS_GAP: begin
        if (halt || !prog) begin
          // In modes 1 and 3 only these commands or leaving operation select 4 end a running program; run is ignored.
          s_nxt.st   = APSS_IDLE;
          s_nxt.held = s_r.resume;
          if (!s_r.resume) begin
            s_nxt.step = 3'h0;
          end
        end else if (s_r.st == APSS_GAP) begin
          if (drive_stopped_in) begin
            s_nxt.st   = APSS_RUN;
            s_nxt.tick = '0;
          end
        end else if (adv) begin
          s_nxt.step   = last ? 3'h0 : s_r.step + 3'h1;
          s_nxt.remain = s_r.timer[s_nxt.step];
          s_nxt.tick   = '0;
          case (s_r.mode)
            apss_pkg::APSS_ONE_PASS: begin
              if (last) begin
                s_nxt.st   = APSS_IDLE;
                s_nxt.done = 1'b1;
              end
            end
            apss_pkg::APSS_CYCLE: begin
              s_nxt.st = APSS_RUN;
            end
            apss_pkg::APSS_PASS_STOP: begin
              s_nxt.st   = last ? APSS_IDLE : APSS_GAP;
              s_nxt.done = last;
            end
            apss_pkg::APSS_CYCLE_STOP: begin
              s_nxt.st = APSS_GAP;
            end
            default: begin
              s_nxt.st = APSS_IDLE;
            end
          endcase
        end else if (s_r.tick == TICK_LAST) begin
          s_nxt.tick   = '0;
          s_nxt.remain = s_r.remain - 16'h0001;
        end else begin
          s_nxt.tick = s_r.tick + TW'(1);
        end
      end
      default: begin
        s_nxt.st = APSS_IDLE;
      end
    endcase

    // Outputs are taken from the next state so they change with it.
    // Settings are read from the next state too, so a write during a step shows at once.
    s_nxt.run  = (s_nxt.st == APSS_RUN) || s_nxt.man_run;
    if (s_nxt.st == APSS_IDLE) begin
      s_nxt.fout = s_nxt.freq[0];
      s_nxt.rev  = prog ? 1'b0 : ext_reverse_in;
      s_nxt.rsel = 2'h0;
    end else begin
      s_nxt.fout = s_nxt.freq[s_nxt.step];
      s_nxt.rev  = s_nxt.dir[s_nxt.step];
      s_nxt.rsel = ramp_of(s_nxt.ramp, s_nxt.step);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_r        <= '0;
      s_r.st     <= APSS_IDLE;
      s_r.mode   <= apss_pkg::APSS_ONE_PASS;
      s_r.freq   <= apss_pkg::FREQ_RST;
      s_r.timer  <= apss_pkg::TIMER_RST;
      s_r.wait_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_out    = s_r.rdata;
  assign avs_waitrequest_out = s_r.wait_r;
  assign run_out             = s_r.run;
  assign freq_out            = s_r.fout;
  assign reverse_out         = s_r.rev;
  assign ramp_pair_out       = s_r.rsel;
  assign step_out            = s_r.step;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_pass_halts: assert property (
    s_r.done |-> !run_out && s_r.st == APSS_IDLE ##1
    run_out == $past(run_cmd_in && !halt))
    else $error("single pass did not halt");
  a_cycle_wraps: assert property (
    adv && last && !halt && prog && s_r.mode == apss_pkg::APSS_CYCLE
    |=> step_out == 3'h0 && run_out)
    else $error("cycling did not wrap to first step");
  a_cycle_ignores: assert property (
    s_r.st == APSS_RUN && prog && !halt && s_r.mode == apss_pkg::APSS_CYCLE
    |=> run_out)
    else $error("cycling stopped without halt command");
  a_gap_stop: assert property (
    adv && !last && !halt && prog && s_r.mode == apss_pkg::APSS_PASS_STOP
    |=> !run_out && s_r.st == APSS_GAP)
    else $error("no stop at step change");
  a_freq_track: assert property (
    s_r.st == APSS_RUN |-> freq_out == s_r.freq[step_out])
    else $error("frequency not from step setpoint");
  a_timer_count: assert property (
    s_r.st == APSS_RUN && !adv && !halt && prog && s_r.tick == TICK_LAST
    |=> s_r.remain == $past(s_r.remain) - 16'h0001)
    else $error("step timer did not count down");
  a_dir_bit: assert property (
    s_r.st != APSS_IDLE |-> reverse_out == s_r.dir[step_out])
    else $error("direction bit mismatch");
  a_ramp_code: assert property (
    s_r.st != APSS_IDLE |-> ramp_pair_out == s_r.ramp[{step_out, 1'b0} +: 2])
    else $error("ramp pair mismatch");
  a_ramp_gate: assert property (
    !prog && $past(!prog) |-> ramp_pair_out == 2'h0)
    else $error("ramp selected outside program mode");
  a_resume_keep: assert property (
    s_r.st == APSS_RUN && halt && s_r.resume |=> step_out == $past(step_out))
    else $error("resume memory lost step");
  a_step_next: assert property (
    adv && !last && !halt && prog |=> step_out == $past(step_out) + 3'h1)
    else $error("step did not advance by one");
  a_fresh_start: assert property (
    s_r.st == APSS_IDLE && prog && run_cmd_in && !halt && !(s_r.held && s_r.resume)
    |=> step_out == 3'h0 && run_out && s_r.remain == $past(s_r.timer[0]))
    else $error("program did not start at main step");
  a_halt_idle: assert property (
    s_r.st != APSS_IDLE && halt |=> !run_out && s_r.st == APSS_IDLE)
    else $error("halt command did not stop program");
  a_gap_exit: assert property (
    s_r.st == APSS_GAP && prog && !halt && drive_stopped_in
    |=> run_out && s_r.st == APSS_RUN)
    else $error("no restart after standstill");
  a_gap_hold: assert property (
    s_r.st == APSS_GAP && prog && !halt && !drive_stopped_in
    |=> !run_out && s_r.st == APSS_GAP)
    else $error("restart before standstill");
  a_ext_rev: assert property (
    prog && s_r.st == APSS_IDLE && !run_cmd_in |=> !reverse_out)
    else $error("external direction used in program mode");
endmodule : apss_sequencer
`default_nettype wire

//--- tb/apss_ramp_model.sv
`timescale 1ns/1ps
`default_nettype none
module apss_ramp_model (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Drive side
  input  wire logic run_in,
  input  wire logic slow_in,
  output logic      stopped_out
);
  logic [3:0] cnt_r;
  // Standstill is reported only after a ramp-down delay, so a gap never ends at once.
  always_ff @(posedge core_clk_in) begin
    if (rst_in || run_in) begin
      cnt_r <= slow_in ? 4'h9 : 4'h1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign stopped_out = !run_in && cnt_r == 4'h0;
endmodule : apss_ramp_model
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TICK = 4;
  logic        core_clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic        run_cmd_in, stop_cmd_in, ext_fault_in, estop_in, ext_reverse_in;
  logic        drive_stopped_in, run_out, reverse_out, slow, rnd_rev, armed;
  logic [6:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, s, rs;
  logic [15:0] freq_out, rmp;
  logic [15:0] fr [8];
  logic [1:0]  ramp_pair_out;
  logic [2:0]  step_out;
  logic [7:0]  dir;
  logic [22:0] pv;
  logic [45:0] e;
  logic [45:0] q [$];
  logic [31:0] rq [$];
  int          fail_count, num_checks, cyc;
  int          md [4] = '{0, 2, 3, 1};
  localparam logic [45:0] IDLE = {23'h400000, 23'h0};

  apss_sequencer #(.TICK_CYCLES(TICK)) dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .run_cmd_in(run_cmd_in),
    .stop_cmd_in(stop_cmd_in), .ext_fault_in(ext_fault_in), .estop_in(estop_in),
    .ext_reverse_in(ext_reverse_in), .drive_stopped_in(drive_stopped_in),
    .run_out(run_out), .freq_out(freq_out), .reverse_out(reverse_out),
    .ramp_pair_out(ramp_pair_out), .step_out(step_out));
  apss_ramp_model ramp_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run_out),
    .slow_in(slow), .stopped_out(drive_stopped_in));

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic bus(input logic wr, input logic [4:0] idx, input logic [31:0] d);
    @(posedge core_clk_in);
    avs_address_in   <= {idx, 2'b00};
    avs_read_in      <= !wr;
    avs_write_in     <= wr;
    avs_writedata_in <= d;
    do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, idx, 32'h0);
  endtask : rd

  // Pulses one command for a clock: 0 run, 1 stop, 2 fault, 3 emergency stop.
  task automatic cmd(input int which);
    @(posedge core_clk_in);
    {estop_in, ext_fault_in, stop_cmd_in, run_cmd_in} <= 4'(4'h1 << which);
    @(posedge core_clk_in);
    {estop_in, ext_fault_in, stop_cmd_in, run_cmd_in} <= 4'h0;
  endtask : cmd

  function automatic logic [45:0] ev(input logic r, input int k);
    return {23'h7fffff, r, 3'(k), dir[k], rmp[2*k+:2], fr[k]};
  endfunction : ev

  task automatic plan(input int passes, input logic gap);
    for (int p = 0; p < passes; p++) begin
      for (int k = 0; k < 8; k++) begin
        if (gap && (p > 0 || k > 0)) begin
          q.push_back(ev(1'b0, k));
        end
        q.push_back(ev(1'b1, k));
      end
    end
    q.push_back(IDLE);
  endtask : plan

  task automatic drain(input int n);
    while (q.size() > n) @(posedge core_clk_in);
  endtask : drain

  // A new drive state is judged whenever run or step moves.
  always @(negedge core_clk_in) begin
    if (armed && {run_out, step_out} !== pv[22:19]) begin
      pv = {run_out, step_out, reverse_out, ramp_pair_out, freq_out};
      e = q.size() > 0 ? q.pop_front() : {23'h7fffff, ~pv};
      chk(32'(pv & e[45:23]), 32'(e[22:0] & e[45:23]));
    end
  end

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    rs <= xs(rs);
    if (rnd_rev) ext_reverse_in <= rs[7];
    if (avs_read_in && avs_waitrequest_out === 1'b0) chk(avs_readdata_out, rq.pop_front());
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    {rst_in, avs_read_in, avs_write_in, slow, rnd_rev, armed} = 6'h20;
    {run_cmd_in, stop_cmd_in, ext_fault_in, estop_in, ext_reverse_in} = 5'h0;
    avs_address_in = 7'h0;
    avs_writedata_in = 32'h0;
    s = 32'h780226a0;
    rs = s;
    pv = 23'h0;
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    armed = 1'b1;
    rd(apss_pkg::REG_FREQ0 + 5'h1, 32'h5dc);
    rd(apss_pkg::REG_TIMER0, 32'h64);
    rd(5'h05, 32'h0);
    bus(1'b1, apss_pkg::REG_FREQ0 + 5'h6, 32'hffff);
    rd(apss_pkg::REG_FREQ0 + 5'h6, 32'h9c40);
    for (int k = 0; k < 8; k++) begin
      s = xs(s);
      fr[k] = 16'(s % 40001);
      bus(1'b1, apss_pkg::REG_FREQ0 + 5'(k), 32'(fr[k]));
      bus(1'b1, apss_pkg::REG_TIMER0 + 5'(k), k < 2 ? 32'(k + 1) : k == 7 ? 32'h3 : 32'h0);
    end
    s = xs(s);
    dir = s[7:0];
    rmp = s[23:8];
    bus(1'b1, apss_pkg::REG_DIR, 32'(dir));
    bus(1'b1, apss_pkg::REG_RAMP, 32'(rmp));
    rd(apss_pkg::REG_DIR, 32'(dir));
    // Outside program mode the external direction is followed and ramp pair one is used.
    ext_reverse_in <= 1'b1;
    q.push_back({23'h47ffff, 1'b1, 3'h0, 1'b1, 2'b00, fr[0]});
    q.push_back(IDLE);
    cmd(0);
    drain(1);
    cmd(1);
    drain(0);
    rnd_rev <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, apss_pkg::REG_CTRL, 32'h4 | 32'(md[i]) << 4 | (md[i] == 1 ? 32'h100 : 32'h0));
      slow <= md[i] == 2;
      plan(md[i] % 2 + 1, md[i] >= 2);
      cmd(0);
      drain(12);
      cmd(0);
      if (md[i] % 2 == 1) begin
        drain(1);
        cmd(md[i] == 1 ? 1 : 3);
      end
      drain(0);
    end
    // Held step and progress are picked up again by the next run.
    q.push_back(ev(1'b1, 7));
    q.push_back(IDLE);
    cmd(0);
    drain(1);
    cmd(2);
    drain(0);
    repeat (5) @(posedge core_clk_in);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
